//--- verilog/lcd_pkg.sv
// Purpose: shared constants and carriers for the character display command block
// Assumes: core clock of 10 MHz, byte-wide writes from a host processor
// Notes: command patterns are matched as (byte & mask) == pattern
package lcd_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_NS = 100;
  localparam int TRST_NS = 1000;           // internal reset completion time
  localparam int RST_CYC = (TRST_NS + CLK_NS - 1) / CLK_NS;
  localparam int FRAME_HZ = 100;            // typical frame frequency
  localparam int FRAME_CYC_DEF = 1000000000 / (FRAME_HZ * CLK_NS);
  localparam int BLINK_W = 6;               // 64 frames per blink period, ~1.5 Hz
  localparam int CONTRAST_W_DEF = 5;

  // ==========================================================
  // command decode patterns
  localparam logic [7:0] CMD_SYS_PAT = 8'h60;
  localparam logic [7:0] CMD_SYS_MSK = 8'hf0;
  localparam logic [7:0] CMD_DISP_PAT = 8'h30;
  localparam logic [7:0] CMD_DISP_MSK = 8'hf8;
  localparam logic [7:0] CMD_PSAVE_PAT = 8'h42;
  localparam logic [7:0] CMD_PSAVE_MSK = 8'hf2;
  localparam logic [7:0] CMD_PWR_PAT = 8'h50;
  localparam logic [7:0] CMD_PWR_MSK = 8'hf8;
  localparam logic [7:0] CMD_VOL = 8'ha8;
  localparam logic [7:0] CMD_ICON_PAT = 8'ha0;
  localparam logic [7:0] CMD_ICON_MSK = 8'hfe;
  localparam logic [7:0] CMD_ADDR_PAT = 8'h80;
  localparam logic [7:0] CMD_ADDR_MSK = 8'h80;
  localparam logic [7:0] CMD_PWR_ALL_ON = 8'h57;
  localparam logic [7:0] CMD_LINE2 = 8'hc0;
  localparam logic [7:0] MSK_ALL = 8'hff;

  // ==========================================================
  // field positions and addresses
  localparam int DISP_ON_BIT = 0;
  localparam int CURSOR_BIT = 1;
  localparam int BLINK_BIT = 2;
  localparam int SAVE_BIT = 0;
  localparam int SAVE_OPT_LSB = 2;
  localparam int ICON_BLINK_BIT = 4;
  localparam int SERIAL_SCL_BIT = 6;
  localparam int SERIAL_SI_BIT = 7;
  localparam logic [6:0] LINE1_ADDR = 7'h30;
  localparam logic [6:0] LINE2_ADDR = 7'h40;
  localparam logic [6:0] LINE3_ADDR = 7'h50;
  localparam logic [2:0] SER_LAST = 3'h7;

  // ==========================================================
  // reset values
  localparam logic [7:0] ICON_RST = 8'h00;
  localparam logic [3:0] SYS_RST = 4'h0;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic is_data;
    logic [7:0] val;
  } lcd_byte_s;

  typedef struct packed {
    logic amp_on;
    logic follower_on;
    logic converter_on;
  } lcd_pwr_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_VOL = 2'b01,
    ST_ICON = 2'b10
  } lcd_state_e;

endpackage

//--- verilog/lcd_bus_rx.sv
// Purpose: turns parallel (two strobe styles) or serial writes into bytes
// Assumes: all pins are asynchronous to core_clk and pass two flip-flops
// Notes: a parallel byte is delivered as a one-cycle pulse after the strobe ends, a serial byte on its eighth clock rise
`timescale 1ns/1ps
module lcd_bus_rx
  import lcd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic sel_68,
  input wire logic cs_n,
  input wire logic wr_strobe,
  input wire logic reg_select,
  input wire logic [7:0] data_in,
  input wire logic serial_sel,
  output lcd_byte_s rx_q,
  output logic rx_valid_q
);

  // ==========================================================
  // pin synchronisers
  logic [11:0] s1_q;
  logic [11:0] s2_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= 12'hfff;
      s2_q <= 12'hfff;
    end else if (ce) begin
      s1_q <= {serial_sel, cs_n, wr_strobe, reg_select, data_in};
      s2_q <= s1_q;
    end
  end

  logic ser_s;
  logic cs_s;
  logic stb_s;
  logic rs_s;
  logic [7:0] dat_s;
  assign {ser_s, cs_s, stb_s, rs_s, dat_s} = s2_q;

  // ==========================================================
  // strobe activity: low write strobe, or high enable in the 68 style
  logic act;
  logic act_q;
  logic sclk_q;
  logic [7:0] sh_q;
  logic [2:0] cnt_q;
  lcd_byte_s cap_q;
  assign act = !cs_s && (sel_68 ? stb_s : !stb_s);

  // capture while the strobe is active, deliver on its end; serial shift
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      act_q <= 1'b0;
      sclk_q <= 1'b1;
      sh_q <= 8'h00;
      cnt_q <= 3'h0;
      cap_q <= '0;
      rx_q <= '0;
      rx_valid_q <= 1'b0;
    end else if (ce) begin
      act_q <= act && !ser_s;
      sclk_q <= dat_s[SERIAL_SCL_BIT];
      rx_valid_q <= 1'b0;
      if (ser_s) begin
        if (cs_s) begin
          cnt_q <= 3'h0;
        end else if (dat_s[SERIAL_SCL_BIT] && !sclk_q) begin
          sh_q <= {sh_q[6:0], dat_s[SERIAL_SI_BIT]};
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == SER_LAST) begin
            rx_q <= '{is_data: rs_s, val: {sh_q[6:0], dat_s[SERIAL_SI_BIT]}};
            rx_valid_q <= 1'b1;
          end
        end
      end else begin
        if (act) begin
          cap_q <= '{is_data: rs_s, val: dat_s};
        end
        if (act_q && !act) begin
          rx_q <= cap_q;
          rx_valid_q <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  rx_single_pulse_a: assert property (
    rx_valid_q && ce |=> !rx_valid_q)
    else $error("received byte pulse longer than one cycle");

endmodule

//--- verilog/lcd_cmd_core.sv
// Purpose: command interpreter and character store of a dot-matrix display driver
// Assumes: host keeps its own waits; bytes come from lcd_bus_rx
// Notes: settings change only on decoded bytes, on frame boundaries or on a reset_in edge
`timescale 1ns/1ps

// Behaviour
// - writes only; reg_select low command, high data
// - system setup byte stored as configuration
// - contrast command then one data byte
// - power save flag and options from command
// - three power enables; 57h on, 50h off
// - bit7 command other than A0H, A1H, A8H sets address; line one 30H
// - line two 40H, line three 50H
// - display, cursor, blink flags from command
// - icon commands take one data byte; blink
// - character store is never cleared by reset
// - reset clears display, save, power, contrast, icons
// - icons alone only while in standby
// - display and icons change on frame boundaries
// - two parallel styles or serial accepted
// - reset_in level at its edge picks style
module lcd_cmd_core
  import lcd_pkg::*;
#(
  parameter int FRAME_CYC = FRAME_CYC_DEF,
  parameter int CONTRAST_W = CONTRAST_W_DEF
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic reset_in,
  input wire logic cs_n,
  input wire logic wr_strobe,
  input wire logic reg_select,
  input wire logic [7:0] data_in,
  input wire logic serial_sel,
  input wire logic [6:0] rd_addr,
  output logic [7:0] rd_data_q,
  output logic [6:0] addr_q,
  output logic bus_68_q,
  output logic ready_q,
  output logic [3:0] sys_cfg_q,
  output logic [CONTRAST_W-1:0] contrast_q,
  output logic save_flag_q,
  output logic [1:0] save_opt_q,
  output lcd_pwr_s pwr_q,
  output logic disp_on_q,
  output logic cursor_q,
  output logic blink_q,
  output logic [7:0] icon0_q,
  output logic [7:0] icon1_q,
  output logic icon_lit_q
);

  localparam int FW = $clog2(FRAME_CYC);
  localparam logic [FW-1:0] FRAME_LAST = FW'(FRAME_CYC - 1);
  localparam logic [3:0] RST_LOAD = 4'(RST_CYC);

  // ==========================================================
  // helpers
  function automatic logic cmd_hit(input logic [7:0] b, input logic [7:0] pat, input logic [7:0] msk);
    return (b & msk) == pat;
  endfunction

  // ==========================================================
  // byte receiver
  lcd_byte_s rx;
  logic rx_v;
  lcd_bus_rx u_rx (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .sel_68(bus_68_q),
    .cs_n(cs_n),
    .wr_strobe(wr_strobe),
    .reg_select(reg_select),
    .data_in(data_in),
    .serial_sel(serial_sel),
    .rx_q(rx),
    .rx_valid_q(rx_v)
  );

  // ==========================================================
  // reset_in pin: synchronise and detect its edges
  logic rin1_q;
  logic rin2_q;
  logic rin3_q;
  logic soft_rst;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rin1_q <= 1'b0;
      rin2_q <= 1'b0;
      rin3_q <= 1'b0;
    end else if (ce) begin
      rin1_q <= reset_in;
      rin2_q <= rin1_q;
      rin3_q <= rin2_q;
    end
  end
  assign soft_rst = ce && (rin2_q != rin3_q);

  // bus style caught from the pin level at its edge
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bus_68_q <= 1'b0;
    end else if (soft_rst) begin
      bus_68_q <= rin2_q;
    end
  end

  // internal reset time: bytes are dropped until it runs out
  logic [3:0] busy_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busy_q <= RST_LOAD;
      ready_q <= 1'b0;
    end else if (soft_rst) begin
      busy_q <= RST_LOAD;
      ready_q <= 1'b0;
    end else if (ce) begin
      if (busy_q != 4'h0) begin
        busy_q <= busy_q - 4'h1;
      end
      ready_q <= (busy_q == 4'h0);
    end
  end

  // ==========================================================
  // accepted bytes and decode
  logic take_cmd;
  logic take_dat;
  logic hit_vol;
  logic hit_icon;
  logic hit_addr;
  assign take_cmd = ce && rx_v && (busy_q == 4'h0) && !rx.is_data;
  assign take_dat = ce && rx_v && (busy_q == 4'h0) && rx.is_data;
  assign hit_vol = cmd_hit(rx.val, CMD_VOL, MSK_ALL);
  assign hit_icon = cmd_hit(rx.val, CMD_ICON_PAT, CMD_ICON_MSK);
  assign hit_addr = cmd_hit(rx.val, CMD_ADDR_PAT, CMD_ADDR_MSK) && !hit_vol && !hit_icon;

  // sequence state: which command waits for its data byte
  lcd_state_e st_q;
  logic icon_sel_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_IDLE;
      icon_sel_q <= 1'b0;
    end else if (soft_rst) begin
      st_q <= ST_IDLE;
    end else if (take_cmd) begin
      if (hit_vol) begin
        st_q <= ST_VOL;
      end else if (hit_icon) begin
        st_q <= ST_ICON;
        icon_sel_q <= rx.val[0];
      end else begin
        st_q <= ST_IDLE;
      end
    end else if (take_dat) begin
      st_q <= ST_IDLE;
    end
  end

  // ==========================================================
  // settings written by commands
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sys_cfg_q <= SYS_RST;
    end else if (take_cmd && cmd_hit(rx.val, CMD_SYS_PAT, CMD_SYS_MSK)) begin
      sys_cfg_q <= rx.val[3:0];
    end
  end

  // contrast level from the data byte after its command
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      contrast_q <= '0;
    end else if (soft_rst) begin
      contrast_q <= '0;
    end else if (take_dat && st_q == ST_VOL) begin
      contrast_q <= rx.val[CONTRAST_W-1:0];
    end
  end

  // power save flag, options, and power circuit enables
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      save_flag_q <= 1'b0;
      save_opt_q <= 2'h0;
      pwr_q <= '0;
    end else if (soft_rst) begin
      save_flag_q <= 1'b0;
      pwr_q <= '0;
    end else if (take_cmd) begin
      if (cmd_hit(rx.val, CMD_PSAVE_PAT, CMD_PSAVE_MSK)) begin
        save_flag_q <= rx.val[SAVE_BIT];
        save_opt_q <= rx.val[SAVE_OPT_LSB+:2];
      end
      if (cmd_hit(rx.val, CMD_PWR_PAT, CMD_PWR_MSK)) begin
        pwr_q <= rx.val[2:0];
      end
    end
  end

  // commanded display-on flag applied at the next frame boundary; cursor and blink flags at once
  logic disp_pend_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      disp_pend_q <= 1'b0;
      cursor_q <= 1'b0;
      blink_q <= 1'b0;
    end else if (soft_rst) begin
      disp_pend_q <= 1'b0;
    end else if (take_cmd && cmd_hit(rx.val, CMD_DISP_PAT, CMD_DISP_MSK)) begin
      disp_pend_q <= rx.val[DISP_ON_BIT];
      cursor_q <= rx.val[CURSOR_BIT];
      blink_q <= rx.val[BLINK_BIT];
    end
  end

  // static icon bytes waiting for the frame boundary
  logic [7:0] icon_pend_q [2];
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      icon_pend_q[0] <= ICON_RST;
      icon_pend_q[1] <= ICON_RST;
    end else if (soft_rst) begin
      icon_pend_q[0] <= ICON_RST;
      icon_pend_q[1] <= ICON_RST;
    end else if (take_dat && st_q == ST_ICON) begin
      icon_pend_q[icon_sel_q] <= rx.val;
    end
  end

  // ==========================================================
  // character store: not reset, contents undefined until written
  logic [7:0] mem [128];
  always_ff @(posedge core_clk) begin
    if (take_dat && st_q == ST_IDLE) begin
      mem[addr_q] <= rx.val;
    end
  end

  // read port for the display side
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_q <= 8'h00;
    end else if (ce) begin
      rd_data_q <= mem[rd_addr];
    end
  end

  // address pointer: set by command, stepped by each stored byte
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      addr_q <= LINE1_ADDR;
    end else if (take_cmd && hit_addr) begin
      addr_q <= rx.val[6:0];
    end else if (take_dat && st_q == ST_IDLE) begin
      addr_q <= addr_q + 7'h01;
    end
  end

  // ==========================================================
  // frame timing and icon blink phase
  logic [FW-1:0] frame_cnt_q;
  logic frame_tick;
  logic [BLINK_W-1:0] blink_cnt_q;
  assign frame_tick = ce && (frame_cnt_q == FRAME_LAST);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      frame_cnt_q <= '0;
      blink_cnt_q <= '0;
    end else if (ce) begin
      frame_cnt_q <= frame_tick ? '0 : frame_cnt_q + FW'(1);
      if (frame_tick) begin
        blink_cnt_q <= blink_cnt_q + BLINK_W'(1);
      end
    end
  end

  // display and icons take effect together on a frame boundary
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      disp_on_q <= 1'b0;
      icon0_q <= ICON_RST;
      icon1_q <= ICON_RST;
    end else if (soft_rst) begin
      disp_on_q <= 1'b0;
      icon0_q <= ICON_RST;
      icon1_q <= ICON_RST;
    end else if (frame_tick) begin
      disp_on_q <= disp_pend_q;
      icon0_q <= icon_pend_q[0];
      icon1_q <= icon_pend_q[1];
    end
  end

  // icon drive: with the display, or alone only in standby, blink gated
  logic icon_any;
  logic icon_blink;
  assign icon_any = (icon0_q != ICON_RST) || (icon1_q != ICON_RST);
  assign icon_blink = icon0_q[ICON_BLINK_BIT] || icon1_q[ICON_BLINK_BIT];
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      icon_lit_q <= 1'b0;
    end else if (ce) begin
      icon_lit_q <= icon_any && (disp_on_q || save_flag_q)
        && !(icon_blink && blink_cnt_q[BLINK_W-1]);
    end
  end

  // ==========================================================
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  data_no_power_a: assert property (
    take_dat |=> $stable(pwr_q) && $stable(save_flag_q))
    else $error("data byte changed a command setting");

  power_all_on_a: assert property (
    take_cmd && rx.val == CMD_PWR_ALL_ON |=> pwr_q == 3'b111)
    else $error("power command did not enable all circuits");

  contrast_load_a: assert property (
    take_dat && st_q == ST_VOL |=> contrast_q == $past(rx.val[CONTRAST_W-1:0]) && st_q == ST_IDLE)
    else $error("contrast byte not loaded");

  save_flag_set_a: assert property (
    take_cmd && cmd_hit(rx.val, CMD_PSAVE_PAT, CMD_PSAVE_MSK) |=> save_flag_q == $past(rx.val[SAVE_BIT]))
    else $error("power save flag mismatch");

  line_two_addr_a: assert property (
    take_cmd && rx.val == CMD_LINE2 |=> addr_q == LINE2_ADDR)
    else $error("second line address not selected");

  addr_step_a: assert property (
    take_dat && st_q == ST_IDLE |=> addr_q == $past(addr_q) + 7'h01)
    else $error("address did not advance after data");

  frame_apply_a: assert property (
    $changed(disp_on_q) |-> $past(frame_tick) || $past(soft_rst))
    else $error("display state changed off a frame boundary");

  reset_defaults_a: assert property (
    soft_rst |=> !disp_on_q && pwr_q == 3'b000 && contrast_q == '0 && !save_flag_q)
    else $error("reset defaults not applied");

  style_latch_a: assert property (
    soft_rst |=> bus_68_q == $past(rin2_q) && !ready_q)
    else $error("bus style not taken from reset level");

  icon_store_a: assert property (
    take_dat && st_q == ST_ICON && !icon_sel_q |=> icon_pend_q[0] == $past(rx.val))
    else $error("icon byte not stored");

endmodule

//--- bench/lcd_host_model.sv
// Purpose: host processor model writing command and data bytes
// Assumes: drives its pins just after the falling edge of core_clk
// Notes: long host waits are scaled down by parameters
`timescale 1ns/1ps
module lcd_host_model #(
  parameter int HOLD = 3,
  parameter int SETTLE = 6,
  parameter int WAIT_RST = 100,
  parameter int PWR_WAIT = 200
) (
  input wire logic core_clk,
  output logic reset_in,
  output logic cs_n,
  output logic wr_strobe,
  output logic reg_select,
  output logic [7:0] data_in,
  output logic serial_sel
);
  logic style68;

  // ==========================================================
  // idle levels
  initial begin
    reset_in = 1'b0;
    cs_n = 1'b1;
    wr_strobe = 1'b1;
    reg_select = 1'b0;
    data_in = 8'h00;
    serial_sel = 1'b0;
    style68 = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // ==========================================================
  // parallel write; strobe level follows the latched bus style
  task automatic put(input logic is_data, input logic [7:0] val);
    @(negedge core_clk);
    reg_select <= is_data;
    data_in <= val;
    cs_n <= 1'b0;
    wr_strobe <= style68;
    idle(HOLD);
    wr_strobe <= ~style68;
    idle(1);
    cs_n <= 1'b1;
    data_in <= ~val; // released bus does not keep its value
    reg_select <= ~is_data;
    idle(SETTLE);
  endtask

  // ==========================================================
  // serial write, msb first, clock still outside the frame
  task automatic put_ser(input logic is_data, input logic [7:0] val);
    @(negedge core_clk);
    serial_sel <= 1'b1;
    cs_n <= 1'b0;
    reg_select <= is_data;
    for (int i = 7; i >= 0; i--) begin
      data_in <= {val[i], 7'h00};
      idle(1);
      data_in[6] <= 1'b1;
      idle(HOLD);
      data_in[6] <= 1'b0;
      idle(HOLD);
    end
    cs_n <= 1'b1;
    data_in <= {~val[0], 7'h7f};
    idle(1);
    serial_sel <= 1'b0;
    idle(SETTLE);
  endtask

  // ==========================================================
  // host sequences
  task automatic fill(input int n, input logic [7:0] val);
    repeat (n) put(1'b1, val);
  endtask

  task automatic power_up();
    put(1'b0, 8'h57);
    idle(PWR_WAIT);
  endtask

  task automatic enter_standby();
    put(1'b0, 8'h30);
    put(1'b0, 8'ha0);
    put(1'b1, 8'h10);
    put(1'b0, 8'ha1);
    put(1'b1, 8'h10);
    put(1'b0, 8'h4f);
    put(1'b0, 8'h50);
  endtask

  task automatic leave_standby();
    put(1'b0, 8'h42);
    power_up();
    put(1'b0, 8'h31);
  endtask

  // reset pin edge; its level picks the bus style
  task automatic pulse_reset(input logic level);
    @(negedge core_clk);
    reset_in <= level;
    wr_strobe <= ~level;
    style68 = level;
    idle(WAIT_RST);
  endtask
endmodule

//--- bench/lcd_char_command_interface_tb_top.sv
// Purpose: self-checking bench for the display command block
// Assumes: host model drives all bus pins
// Notes: frame period shortened to 16 cycles
`timescale 1ns/1ps
module lcd_char_command_interface_tb_top;
  import lcd_pkg::*;
  localparam int FRM = 16;
  logic core_clk, rstn, reset_in, cs_n, wr_strobe, reg_select, serial_sel;
  logic [7:0] data_in, rd_data_q, icon0_q, icon1_q;
  logic [6:0] rd_addr, addr_q;
  logic bus_68_q, ready_q, save_flag_q, disp_on_q, cursor_q, blink_q, icon_lit_q;
  logic [3:0] sys_cfg_q;
  logic [4:0] contrast_q;
  logic [1:0] save_opt_q;
  lcd_pwr_s pwr_q;
  int fails, num_checks;

  // ==========================================================
  // instances
  lcd_host_model host (.core_clk(core_clk), .reset_in(reset_in), .cs_n(cs_n), .wr_strobe(wr_strobe),
    .reg_select(reg_select), .data_in(data_in), .serial_sel(serial_sel));
  lcd_cmd_core #(.FRAME_CYC(FRM)) DUT (.core_clk(core_clk), .rstn(rstn), .ce(1'b1), .reset_in(reset_in),
    .cs_n(cs_n), .wr_strobe(wr_strobe), .reg_select(reg_select), .data_in(data_in), .serial_sel(serial_sel),
    .rd_addr(rd_addr), .rd_data_q(rd_data_q), .addr_q(addr_q), .bus_68_q(bus_68_q), .ready_q(ready_q),
    .sys_cfg_q(sys_cfg_q), .contrast_q(contrast_q), .save_flag_q(save_flag_q), .save_opt_q(save_opt_q),
    .pwr_q(pwr_q), .disp_on_q(disp_on_q), .cursor_q(cursor_q), .blink_q(blink_q), .icon0_q(icon0_q),
    .icon1_q(icon1_q), .icon_lit_q(icon_lit_q));

  always #50 core_clk = ~core_clk;

  // ==========================================================
  // compare and report
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_mem(input logic [6:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    rd_addr <= a;
    repeat (3) @(negedge core_clk);
    chk("store", exp, rd_data_q);
  endtask

  task automatic frame_wait();
    repeat (FRM + 4) @(negedge core_clk);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    for (int i = 0; i < 40 && ready_q !== 1'b1; i++) @(negedge core_clk);
    chk("ready", 8'h01, {7'h0, ready_q});
    host.idle(100);
    chk("display", 8'h00, {7'h0, disp_on_q});
    chk("save", 8'h00, {7'h0, save_flag_q});
    chk("power", 8'h00, {5'h0, pwr_q});
    chk("contrast", 8'h00, {3'h0, contrast_q});
    chk("icons", 8'h00, icon0_q | icon1_q);
    chk("style", 8'h00, {7'h0, bus_68_q});
    $display("test reset done");
  endtask

  task automatic t_init();
    logic [7:0] cmds [3];
    cmds = '{8'hb0, 8'hc0, 8'hd0};
    host.put(1'b0, 8'h64);
    chk("setup", 8'h04, {4'h0, sys_cfg_q});
    host.put(1'b0, 8'ha8);
    host.put(1'b1, 8'hf5);
    chk("contrast", 8'h15, {3'h0, contrast_q});
    host.put(1'b0, 8'ha8);
    host.put(1'b1, 8'h00);
    chk("contrast", 8'h00, {3'h0, contrast_q});
    host.power_up();
    chk("power", 8'h07, {5'h0, pwr_q});
    foreach (cmds[i]) begin
      host.put(1'b0, cmds[i]);
      chk("addr", {1'b0, cmds[i][6:0]}, {1'b0, addr_q});
      host.fill(13, 8'h20);
      chk("addr", {1'b0, cmds[i][6:0]} + 8'd13, {1'b0, addr_q});
      chk_mem(cmds[i][6:0] + 7'd12, 8'h20);
    end
    host.put(1'b0, 8'hb0);
    host.put(1'b1, 8'h48);
    host.put(1'b1, 8'h49);
    chk_mem(7'h30, 8'h48);
    chk_mem(7'h31, 8'h49);
    $display("test init done");
  endtask

  task automatic t_display();
    host.put(1'b0, 8'h36);
    frame_wait();
    chk("flags", 8'h06, {5'h0, blink_q, cursor_q, disp_on_q});
    host.put(1'b0, 8'h31);
    host.put(1'b0, 8'ha0);
    host.put(1'b1, 8'h10);
    host.put(1'b0, 8'ha1);
    host.put(1'b1, 8'h08);
    frame_wait();
    chk("flags", 8'h01, {5'h0, blink_q, cursor_q, disp_on_q});
    chk("icon0", 8'h10, icon0_q);
    chk("icon1", 8'h08, icon1_q);
    $display("test display done");
  endtask

  task automatic t_standby();
    int hi;
    hi = 0;
    host.enter_standby();
    frame_wait();
    chk("save", 8'h01, {7'h0, save_flag_q});
    chk("options", 8'h03, {6'h0, save_opt_q});
    chk("power", 8'h00, {5'h0, pwr_q});
    chk("display", 8'h00, {7'h0, disp_on_q});
    repeat (1100) begin
      @(negedge core_clk);
      if (icon_lit_q === 1'b1) hi++;
    end
    chk("blinking", 8'h01, {7'h0, hi > 0 && hi < 1100});
    // save flag off with the display still off: icons must go dark
    host.put(1'b0, 8'h42);
    chk("alone", 8'h00, {7'h0, icon_lit_q});
    host.leave_standby();
    frame_wait();
    chk("save", 8'h00, {7'h0, save_flag_q});
    chk("power", 8'h07, {5'h0, pwr_q});
    chk("display", 8'h01, {7'h0, disp_on_q});
    $display("test standby done");
  endtask

  task automatic t_serial();
    host.put_ser(1'b0, 8'hb5);
    chk("addr", 8'h35, {1'b0, addr_q});
    host.put_ser(1'b1, 8'h5a);
    chk("addr", 8'h36, {1'b0, addr_q});
    chk_mem(7'h35, 8'h5a);
    host.put_ser(1'b0, 8'ha8);
    host.put_ser(1'b1, 8'h0a);
    chk("contrast", 8'h0a, {3'h0, contrast_q});
    $display("test serial done");
  endtask

  task automatic t_softrst();
    host.pulse_reset(1'b1);
    chk("style", 8'h01, {7'h0, bus_68_q});
    chk("contrast", 8'h00, {3'h0, contrast_q});
    chk("power", 8'h00, {5'h0, pwr_q});
    chk("display", 8'h00, {7'h0, disp_on_q});
    chk("icons", 8'h00, icon0_q | icon1_q);
    chk_mem(7'h35, 8'h5a);
    host.put(1'b0, 8'h57);
    chk("power", 8'h07, {5'h0, pwr_q});
    $display("test soft reset done");
  endtask

  // ==========================================================
  // watchdog against a hung run
  initial begin
    repeat (60000) @(posedge core_clk);
    fails++;
    $display("[ERR] watchdog expected finish seen timeout");
    results();
  end

  // ==========================================================
  // main sequence
  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    rd_addr = 7'h00;
    fails = 0;
    num_checks = 0;
    repeat (12) @(negedge core_clk);
    rstn = 1'b1;
    t_reset();
    t_init();
    t_display();
    t_standby();
    t_serial();
    t_softrst();
    results();
  end
endmodule
